// ---- logic/ebc_defs.svh ----
// Purpose: offsets, field positions, reset values and counts of the external bus controller
// Assumes: register port with byte addresses, one 32-bit word per register
// Notes:   included by the package and the controller
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// register offsets
`define EBC_OFS_CFG      8'h00
`define EBC_OFS_ADDR     8'h04
`define EBC_OFS_WDATA    8'h08
`define EBC_OFS_CMD      8'h0C
`define EBC_OFS_STATUS   8'h10

// configuration fields
`define EBC_CFG_MCTC_LO  0
`define EBC_CFG_MCTC_HI  3
`define EBC_CFG_MUX      4
`define EBC_CFG_ALE_EXT  5
`define EBC_CFG_TRI      6
`define EBC_CFG_RDY_EN   7
`define EBC_CFG_RDY_ASY  8
`define EBC_CFG_SHARE    9
`define EBC_CFG_W        10
`define EBC_CFG_RST      10'h00F

// command fields
`define EBC_CMD_START    0
`define EBC_CMD_WRITE    1

// status fields
`define EBC_ST_BUSY      0
`define EBC_ST_HELD      1
`define EBC_ST_SHARE     2
`define EBC_ST_RD_LO     16

// timing counts in link clock cycles
`define EBC_MCTC_MAX     4'hF
`define EBC_CAP_LAG      2

`endif

// ---- logic/ebc_pkg.sv ----
// Purpose: types of the external bus controller
// Assumes: constants come from ebc_defs.svh
// Notes:   link state machine encoding is left to the tools
package ebc_pkg;
  `include "ebc_defs.svh"

  typedef enum logic [3:0] {
    L_IDLE,
    L_ALE,
    L_CMD,
    L_TRI,
    L_MUX,
    L_REL,
    L_HELD,
    L_REGAIN
  } ebc_lst_e;

  typedef logic [`EBC_CFG_W-1:0] ebc_cfg_t;
endpackage

// ---- logic/ebc_sync2.sv ----
// Purpose: two flip-flop synchroniser for levels and toggles
// Assumes: synchronous active-low reset in the destination domain
// Notes:   the first stage feeds the second stage only
`timescale 1ns/1ns
module ebc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  input  wire logic [W-1:0] i_rst_val,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // two stages, reset to the given idle level
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_r <= i_rst_val;              // idle level, so no false edge after reset
      o_q    <= i_rst_val;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// ---- logic/ebc_bus_ctrl.sv ----
// Purpose: external bus cycle control with ready waits, turnaround, hold arbitration
// Assumes: i_ref_clk core side at 100 MHz, i_link_clk bus reference clock side
// Notes:   config words are held stable while busy, so they cross by handshake
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`include "ebc_defs.svh"
module ebc_bus_ctrl (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_link_clk,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  output logic             o_ale,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_cs_n,
  output logic             o_cs_oe,
  output logic             o_ctl_oe,
  output logic      [15:0] o_addr,
  output logic      [15:0] o_ad_out,
  output logic             o_ad_oe,
  input  wire logic [15:0] i_ad_in,
  input  wire logic        i_ready_n,
  input  wire logic        i_hold_n,
  output logic             o_bus_release_ack_n,
  output logic             o_bus_regain_request_n,
  input  wire logic [15:0] i_onchip_extension_ram_addr,
  input  wire logic        i_onchip_extension_ram_rd_n,
  input  wire logic        i_onchip_extension_ram_wr_n,
  output logic             o_onchip_extension_ram_we,
  output logic      [15:0] o_onchip_extension_ram_waddr,
  output logic      [15:0] o_onchip_extension_ram_wdata,
  input  wire logic [15:0] i_onchip_extension_ram_rdata
);
  import ebc_pkg::*;

  // ---------------- core side ----------------
  ebc_cfg_t    cfg_r;
  logic [15:0] addr_r;
  logic [15:0] wdata_r;
  logic        write_r;
  logic        busy_r;
  logic        req_tog_r;
  logic        done_seen_r;
  logic [15:0] rdata_r;
  logic [1:0]  ref_in_s;
  logic        done_tog_l;
  logic        held_l;
  logic [15:0] cap_l;

  ebc_sync2 #(.W(2)) u_ref_sync (
    .i_clk     (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_d       ({held_l, done_tog_l}),
    .i_rst_val (2'h0),
    .o_q       (ref_in_s)
  );

  // software settings, frozen while a cycle is outstanding
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_r   <= `EBC_CFG_RST;
      addr_r  <= 16'h0000;
      wdata_r <= 16'h0000;
      write_r <= 1'b0;
    end else if (i_reg_wr && !busy_r) begin
      if (i_reg_addr == `EBC_OFS_CFG)
        cfg_r <= i_reg_wdata[`EBC_CFG_W-1:0];
      if (i_reg_addr == `EBC_OFS_ADDR)
        addr_r <= i_reg_wdata[15:0];
      if (i_reg_addr == `EBC_OFS_WDATA)
        wdata_r <= i_reg_wdata[15:0];
      if (i_reg_addr == `EBC_OFS_CMD)
        write_r <= i_reg_wdata[`EBC_CMD_WRITE];
    end
  end

  // start request toggle and completion handshake
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      busy_r      <= 1'b0;
      req_tog_r   <= 1'b0;
      done_seen_r <= 1'b0;
      rdata_r     <= 16'h0000;
    end else begin
      if (busy_r && (ref_in_s[0] != done_seen_r)) begin
        busy_r      <= 1'b0;
        done_seen_r <= ref_in_s[0];
        rdata_r     <= cap_l;           // stable until the next cycle completes
      end else if (i_reg_wr && !busy_r && i_reg_addr == `EBC_OFS_CMD
                   && i_reg_wdata[`EBC_CMD_START]) begin
        busy_r    <= 1'b1;
        req_tog_r <= ~req_tog_r;
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `EBC_OFS_CFG:    o_reg_rdata <= {22'h0, cfg_r};
        `EBC_OFS_ADDR:   o_reg_rdata <= {16'h0, addr_r};
        `EBC_OFS_WDATA:  o_reg_rdata <= {16'h0, wdata_r};
        `EBC_OFS_CMD:    o_reg_rdata <= {30'h0, write_r, 1'b0};
        `EBC_OFS_STATUS: o_reg_rdata <= {rdata_r, 13'h0, cfg_r[`EBC_CFG_SHARE],
                                         ref_in_s[1], busy_r};
        default:         o_reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

  // ---------------- link side ----------------
  logic        lrst_n;
  logic [4:0]  lk_s;
  logic        rdy_x_r;
  logic [15:0] ad_s;
  logic [15:0] xa_s;
  logic        xwr_d_r;
  ebc_lst_e    st_r;
  logic [4:0]  cnt_r;
  logic        waited_r;
  logic        ack_tog_r;
  logic [`EBC_CAP_LAG-1:0] cap_pipe_r;
  logic        pend;
  logic        rdy_high;
  logic        mux_l;
  logic        tri_l;

  ebc_sync2 #(.W(1)) u_rst_sync (
    .i_clk     (i_link_clk),
    .i_rst_n   (1'b1),
    .i_d       (i_rst_n),
    .i_rst_val (1'b0),
    .o_q       (lrst_n)
  );

  // lk_s: 0 request toggle, 1 hold_n, 2 ready_n, 3 onchip_extension_ram rd_n, 4 onchip_extension_ram wr_n
  ebc_sync2 #(.W(5)) u_lnk_sync (
    .i_clk     (i_link_clk),
    .i_rst_n   (lrst_n),
    .i_d       ({i_onchip_extension_ram_wr_n, i_onchip_extension_ram_rd_n, i_ready_n, i_hold_n, req_tog_r}),
    .i_rst_val (5'h1E),
    .o_q       (lk_s)
  );

  ebc_sync2 #(.W(32)) u_ad_sync (
    .i_clk     (i_link_clk),
    .i_rst_n   (lrst_n),
    .i_d       ({i_onchip_extension_ram_addr, i_ad_in}),
    .i_rst_val (32'h0000_0000),
    .o_q       ({xa_s, ad_s})
  );

  // extra ready stage used only in asynchronous mode
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) rdy_x_r <= 1'b1;
    else         rdy_x_r <= lk_s[2];
  end

  assign pend     = (lk_s[0] != ack_tog_r);
  assign mux_l    = cfg_r[`EBC_CFG_MUX];
  assign tri_l    = cfg_r[`EBC_CFG_TRI];
  assign rdy_high = cfg_r[`EBC_CFG_RDY_ASY] ? rdy_x_r : lk_s[2];

  // bus cycle and arbitration sequencer
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      st_r      <= L_IDLE;
      cnt_r     <= 5'h00;
      waited_r  <= 1'b0;
      ack_tog_r <= 1'b0;
      o_ale     <= 1'b0;
      o_rd_n    <= 1'b1;
      o_wr_n    <= 1'b1;
      o_cs_n    <= 1'b1;
      o_cs_oe   <= 1'b1;
      o_ctl_oe  <= 1'b1;
      o_addr    <= 16'h0000;
      o_bus_release_ack_n <= 1'b1;
    end else begin
      unique case (st_r)
        L_IDLE: begin
          if (!lk_s[1]) begin
            o_cs_n <= 1'b1;
            st_r   <= L_REL;
          end else if (pend) begin
            o_ale  <= 1'b1;
            o_cs_n <= 1'b0;
            o_addr <= addr_r;
            cnt_r  <= {4'h0, cfg_r[`EBC_CFG_ALE_EXT]} + {4'h0, mux_l};
            st_r   <= L_ALE;
          end
        end
        L_ALE: begin
          if (cnt_r == 5'h00) begin
            o_ale    <= 1'b0;
            o_rd_n   <= write_r;
            o_wr_n   <= ~write_r;
            waited_r <= 1'b0;
            cnt_r    <= {1'b0, `EBC_MCTC_MAX - cfg_r[`EBC_CFG_MCTC_HI:`EBC_CFG_MCTC_LO]};
            st_r     <= L_CMD;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        L_CMD: begin
          if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
          end else if (cfg_r[`EBC_CFG_RDY_EN] && (rdy_high
                       || (cfg_r[`EBC_CFG_RDY_ASY] && !waited_r))) begin
            waited_r <= 1'b1;
          end else begin
            o_rd_n    <= 1'b1;
            o_wr_n    <= 1'b1;
            ack_tog_r <= ~ack_tog_r;
            if (tri_l)      st_r <= L_TRI;
            else if (mux_l) st_r <= L_MUX;
            else begin
              o_cs_n <= 1'b1;
              st_r   <= L_IDLE;
            end
          end
        end
        L_TRI: begin
          if (mux_l) st_r <= L_MUX;
          else begin
            o_cs_n <= 1'b1;
            st_r   <= L_IDLE;
          end
        end
        L_MUX: begin
          o_cs_n <= 1'b1;
          st_r   <= L_IDLE;
        end
        L_REL: begin
          o_cs_oe  <= 1'b0;
          o_ctl_oe <= 1'b0;
          o_bus_release_ack_n <= 1'b0;
          st_r     <= L_HELD;
        end
        L_HELD: begin
          if (lk_s[1]) begin
            o_bus_release_ack_n <= 1'b1;
            o_cs_oe  <= 1'b1;
            o_ctl_oe <= 1'b1;
            st_r     <= L_REGAIN;
          end
        end
        L_REGAIN: st_r <= L_IDLE;
        default:  st_r <= L_IDLE;
      endcase
    end
  end

  // read data capture: the synchroniser lag matches the pipe length
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      cap_pipe_r <= '0;
      cap_l      <= 16'h0000;
      done_tog_l <= 1'b0;
    end else begin
      cap_pipe_r <= {cap_pipe_r[`EBC_CAP_LAG-2:0],
                     (st_r == L_CMD) && (o_rd_n == 1'b0 || o_wr_n == 1'b0)
                     && (cnt_r == 5'h00) && !(cfg_r[`EBC_CFG_RDY_EN] && (rdy_high
                     || (cfg_r[`EBC_CFG_RDY_ASY] && !waited_r)))};
      if (cap_pipe_r[`EBC_CAP_LAG-1]) begin
        if (!write_r) cap_l <= ad_s;
        done_tog_l <= ~done_tog_l;
      end
    end
  end

  // regain request and held indication
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      o_bus_regain_request_n <= 1'b1;
      held_l                 <= 1'b0;
    end else begin
      o_bus_regain_request_n <= !((st_r == L_HELD) && pend);
      held_l                 <= (st_r == L_HELD);
    end
  end

  // address/data pins: own cycles, or shared ram reads while held
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      o_ad_out <= 16'h0000;
      o_ad_oe  <= 1'b0;
    end else if (st_r == L_HELD) begin
      o_ad_out <= i_onchip_extension_ram_rdata;
      o_ad_oe  <= cfg_r[`EBC_CFG_SHARE] && !lk_s[3];
    end else if (st_r == L_IDLE && lk_s[1] && pend) begin
      o_ad_out <= mux_l ? addr_r : wdata_r;
      o_ad_oe  <= mux_l | write_r;
    end else if (st_r == L_ALE && cnt_r == 5'h00) begin
      o_ad_out <= wdata_r;
      o_ad_oe  <= write_r;
    end else if (st_r == L_CMD) begin
      o_ad_oe  <= write_r && (o_wr_n == 1'b0);
    end else begin
      o_ad_oe  <= 1'b0;
    end
  end

  // shared ram writes commit on the rising edge of the write strobe
  always_ff @(posedge i_link_clk) begin
    if (!lrst_n) begin
      xwr_d_r      <= 1'b1;
      o_onchip_extension_ram_we    <= 1'b0;
      o_onchip_extension_ram_waddr <= 16'h0000;
      o_onchip_extension_ram_wdata <= 16'h0000;
    end else begin
      xwr_d_r   <= lk_s[4];
      o_onchip_extension_ram_we <= (st_r == L_HELD) && cfg_r[`EBC_CFG_SHARE]
                   && lk_s[4] && !xwr_d_r;
      o_onchip_extension_ram_waddr <= xa_s;
      o_onchip_extension_ram_wdata <= ad_s;
    end
  end
endmodule

// ---- verif/ebc_bus_ctrl_properties.sv ----
// Purpose: concurrent checks on the link side of the bus controller
// Assumes: link domain outputs, core reset delayed into the link domain as disable
// Notes:   bound to ebc_bus_ctrl from the bench top file
`timescale 1ns/1ns
module ebc_bus_ctrl_properties (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  input wire logic i_hold_n,
  input wire logic i_onchip_extension_ram_wr_n,
  input wire logic o_cs_n,
  input wire logic o_cs_oe,
  input wire logic o_ctl_oe,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_ale,
  input wire logic o_bus_release_ack_n,
  input wire logic o_bus_regain_request_n,
  input wire logic o_onchip_extension_ram_we
);
  logic [3:0] rst_dly_r = 4'h0;
  // link outputs settle two link clocks after the core reset lifts; wait a little longer
  always @(posedge i_link_clk) rst_dly_r <= {rst_dly_r[2:0], i_rst_n};
  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (!rst_dly_r[3]);
  // released bus: chip select and control drivers off and no own strobes
  AST_ACK_DRV_OFF: assert property (!o_bus_release_ack_n |-> !o_cs_oe && !o_ctl_oe)
    else $error("drivers on while bus released");
  AST_HELD_QUIET: assert property (!o_bus_release_ack_n |-> o_rd_n && o_wr_n && !o_ale)
    else $error("own cycle while bus released");
  // chip select parked high before its driver turns off
  AST_CS_HIGH_OFF: assert property ($fell(o_cs_oe) |-> o_cs_n && $past(o_cs_n))
    else $error("chip select not high at release");
  AST_GRANT_AFTER_CYCLE: assert property ($fell(o_ctl_oe) |-> $past(o_rd_n) && $past(o_wr_n))
    else $error("bus granted inside a cycle");
  AST_GRANT_BOUND: assert property ($fell(i_hold_n) |-> ##[1:40] (!o_bus_release_ack_n || i_hold_n))
    else $error("hold not acknowledged in time");
  AST_REGAIN_ON_HOLD: assert property ($rose(o_bus_release_ack_n) |-> $past(i_hold_n, 2))
    else $error("regain without hold going high");
  // request only while held, kept until the bus comes back
  AST_REQ_KEPT: assert property (!o_bus_regain_request_n && !o_bus_release_ack_n |=>
    !o_bus_regain_request_n || $rose(o_bus_release_ack_n))
    else $error("bus request dropped while held");
  AST_REQ_HELD: assert property (!o_bus_regain_request_n |->
    !o_bus_release_ack_n || !$past(o_bus_release_ack_n))
    else $error("bus request while owning bus");
  AST_ONCHIP_EXTENSION_RAM_WE: assert property (o_onchip_extension_ram_we |-> !o_bus_release_ack_n && $past(i_onchip_extension_ram_wr_n, 2)
    ##1 !o_onchip_extension_ram_we)
    else $error("bad shared ram write pulse");
  COV_HELD: cover property ($fell(o_bus_release_ack_n));
  COV_ONCHIP_EXTENSION_RAM: cover property ($rose(o_onchip_extension_ram_we));
  COV_READ: cover property ($fell(o_rd_n));
endmodule

// ---- verif/ebc_ext_mem.sv ----
// Purpose: external memory answering bus cycles with ready control
// Assumes: demux addressing on the address port, 256 words
// Notes:   read data held three link clocks then toggled every clock
`timescale 1ns/1ns
module ebc_ext_mem (
  input  wire logic        i_link_clk,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_ad_out,
  input  wire logic [7:0]  i_wait,
  output logic      [15:0] o_ad_in,
  output logic             o_ready_n
);
  logic [15:0] mem [0:255];
  logic [31:0] wlat_r;
  logic [7:0]  cnt_r;
  logic [1:0]  hold_r;
  logic        wr_d_r;
  // write lands when the strobe rises
  always_ff @(posedge i_link_clk) begin
    wr_d_r <= i_wr_n;
    if (!i_wr_n) wlat_r <= {i_addr, i_ad_out};
    if (i_wr_n && !wr_d_r) mem[wlat_r[23:16]] <= wlat_r[15:0];
  end
  // ready after i_wait strobe clocks, withdrawn once the strobe rises
  always_ff @(posedge i_link_clk) begin
    if (!i_rd_n || !i_wr_n) begin
      cnt_r     <= cnt_r + 8'h01;
      o_ready_n <= !(cnt_r >= i_wait);
    end else begin
      cnt_r     <= 8'h00;
      o_ready_n <= 1'b1;
    end
  end
  // data settles half a clock into the strobe, ahead of the strobe-rise sample;
  // released data lines keep the read value three clocks, then toggle every clock
  always_ff @(negedge i_link_clk) begin
    if (!i_rd_n) begin
      o_ad_in <= mem[i_addr[7:0]];
      hold_r  <= 2'h3;
    end else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
    else o_ad_in <= ~o_ad_in;
  end
endmodule

// ---- verif/ebc_bus_ctrl_bench.sv ----
// Purpose: self-checking bench for bus cycles, ready, turnaround and hold
// Assumes: 100 MHz core clock, 64 ns link clock
// Notes:   link monitor counts ale, strobe and tail clocks of each cycle
`timescale 1ns/1ns
`include "ebc_defs.svh"
module ebc_bus_ctrl_bench;
  import ebc_pkg::*;
  logic        i_ref_clk = 0, i_link_clk = 0, i_rst_n, i_reg_wr, i_reg_rd, i_hold_n;
  logic        i_onchip_extension_ram_rd_n, i_onchip_extension_ram_wr_n, i_ready_n, xm_en, cs_d = 1;
  logic        o_ale, o_rd_n, o_wr_n, o_cs_n, o_cs_oe, o_ctl_oe, o_ad_oe, o_onchip_extension_ram_we;
  logic        o_bus_release_ack_n, o_bus_regain_request_n;
  logic [7:0]  i_reg_addr, wt;
  logic [31:0] i_reg_wdata, o_reg_rdata, st;
  logic [15:0] i_onchip_extension_ram_addr, i_onchip_extension_ram_rdata, xm_ad, mem_ad, i_ad_in, o_addr, o_ad_out;
  logic [15:0] o_onchip_extension_ram_waddr, o_onchip_extension_ram_wdata, xw_a, xw_d;
  int          n_mismatch = 0, comparisons = 0, cyc = 0, ale_n, stb_n, tail_n, tail0 = -1;
  assign i_ad_in = xm_en ? xm_ad : mem_ad;
  ebc_bus_ctrl uut (.i_ref_clk, .i_rst_n, .i_link_clk, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
    .i_reg_rd, .o_reg_rdata, .o_ale, .o_rd_n, .o_wr_n, .o_cs_n, .o_cs_oe, .o_ctl_oe, .o_addr,
    .o_ad_out, .o_ad_oe, .i_ad_in, .i_ready_n, .i_hold_n, .o_bus_release_ack_n,
    .o_bus_regain_request_n, .i_onchip_extension_ram_addr, .i_onchip_extension_ram_rd_n, .i_onchip_extension_ram_wr_n, .o_onchip_extension_ram_we,
    .o_onchip_extension_ram_waddr, .o_onchip_extension_ram_wdata, .i_onchip_extension_ram_rdata);
  ebc_ext_mem u_mem (.i_link_clk, .i_rd_n(o_rd_n), .i_wr_n(o_wr_n), .i_addr(o_addr),
    .i_ad_out(o_ad_out), .i_wait(wt), .o_ad_in(mem_ad), .o_ready_n(i_ready_n));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  initial begin
    #3;
    forever #32 i_link_clk = ~i_link_clk;
  end
  // link monitor: restart counts when chip select falls
  always @(posedge i_link_clk) begin
    if (cs_d && !o_cs_n) begin
      ale_n = 0; stb_n = 0; tail_n = 0;
    end
    if (o_ale) ale_n++;
    if (!o_rd_n || !o_wr_n) stb_n++;
    else if (!o_cs_n && stb_n > 0) tail_n++;
    if (o_onchip_extension_ram_we) begin
      xw_a = o_onchip_extension_ram_waddr; xw_d = o_onchip_extension_ram_wdata;
    end
    cs_d = o_cs_n;
  end
  // hang guard
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a; i_reg_wdata <= d; i_reg_wr <= 1;
    @(posedge i_ref_clk);
    i_reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_ref_clk);
    i_reg_addr <= a; i_reg_rd <= 1;
    @(posedge i_ref_clk);
    i_reg_rd <= 0;
    #1 st = o_reg_rdata;
  endtask
  task poll;
    for (int i = 0; i < 200; i++) begin
      rd(`EBC_OFS_STATUS);
      if (st[0] === 1'b0) break;
    end
  endtask
  task wait_ack(input logic v);
    for (int i = 0; i < 300 && o_bus_release_ack_n !== v; i++) @(posedge i_ref_clk);
  endtask
  // reset values, unmapped read, read back
  task t_regs;
    rd(`EBC_OFS_CFG); chk(st, 32'h0000000F);
    rd(8'h20); chk(st, 32'h0);
    wr(`EBC_OFS_CFG, 32'h2AB); rd(`EBC_OFS_CFG); chk(st, 32'h2AB);
  endtask
  // one bus cycle; d is write data or expected read data
  task t_cyc(input logic [31:0] c, input logic w, input logic [15:0] a, input logic [15:0] d,
             input logic [7:0] wn, input int e_ale, input int e_stb, input int e_tail);
    wt <= wn;
    wr(`EBC_OFS_CFG, c); wr(`EBC_OFS_ADDR, a); wr(`EBC_OFS_WDATA, d);
    wr(`EBC_OFS_CMD, {30'h0, w, 1'b1});
    poll;
    if (tail0 < 0) tail0 = tail_n;
    chk(ale_n, e_ale);
    if (c[7]) chk(stb_n >= e_stb, 1);
    else chk(stb_n, e_stb);
    chk(tail_n - tail0, e_tail);
    if (!w) chk(st[31:16], d);
  endtask
  // external master strobe on the shared ram, 900 ns per access
  task xs(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_onchip_extension_ram_addr <= a; i_onchip_extension_ram_rdata <= ~a; xm_ad <= d; xm_en <= 1;
    repeat (30) @(posedge i_ref_clk);
    if (w) i_onchip_extension_ram_wr_n <= 0;
    else i_onchip_extension_ram_rd_n <= 0;
    repeat (30) @(posedge i_ref_clk);
    if (!w) chk({o_ad_oe, o_ad_out}, {1'b1, ~a});
    i_onchip_extension_ram_wr_n <= 1; i_onchip_extension_ram_rd_n <= 1;
    repeat (30) @(posedge i_ref_clk);
    if (!w) chk(o_ad_oe, 0);
    xm_en <= 0;
  endtask
  // hold raised during a long cycle, optional pending access while held
  task t_hold(input logic pend);
    wr(`EBC_OFS_CFG, 32'h200); wr(`EBC_OFS_CMD, 32'h3);
    // raise hold only once the long cycle is on the pins
    while (o_cs_n !== 1'b0) @(posedge i_ref_clk);
    i_hold_n <= 0;
    wait_ack(0);
    // let the held flag and the completion cross back to the core side
    repeat (20) @(posedge i_ref_clk);
    chk(stb_n, 16);
    rd(`EBC_OFS_STATUS); chk(st[2:0], 3'b110);
    xs(1, 16'h0020, 16'hBEEF); chk({xw_a, xw_d}, 32'h0020BEEF);
    xs(0, 16'h0021, 16'h0);
    if (pend) begin
      wr(`EBC_OFS_ADDR, 32'h10); wr(`EBC_OFS_CMD, 32'h1);
      repeat (60) @(posedge i_ref_clk);
      chk(o_bus_regain_request_n, 0);
      rd(`EBC_OFS_STATUS); chk(st[1:0], 2'b11);
    end else chk(o_bus_regain_request_n, 1);
    i_hold_n <= 1;
    wait_ack(1);
    chk(o_bus_release_ack_n, 1);
    poll;
    if (pend) chk(st[31:16], 16'h1234);
  endtask
  initial begin
    i_rst_n = 0; i_reg_wr = 0; i_reg_rd = 0; i_reg_addr = 0; i_reg_wdata = 0; i_hold_n = 1;
    i_onchip_extension_ram_rd_n = 1; i_onchip_extension_ram_wr_n = 1; i_onchip_extension_ram_addr = 0; i_onchip_extension_ram_rdata = 0; xm_en = 0;
    xm_ad = 0; wt = 0;
    repeat (8) @(posedge i_ref_clk);
    i_rst_n <= 1;
    repeat (40) @(posedge i_ref_clk);
    t_regs;
    t_cyc(32'h00F, 1, 16'h10, 16'h1234, 0, 1, 1, 0);
    t_cyc(32'h00C, 0, 16'h10, 16'h1234, 0, 1, 4, 0);
    t_cyc(32'h05F, 1, 16'h11, 16'hA55A, 0, 2, 1, 2);
    t_cyc(32'h03F, 0, 16'h11, 16'hA55A, 0, 3, 1, 1);
    t_cyc(32'h08F, 1, 16'h12, 16'h0F0F, 5, 1, 6, 0);
    t_cyc(32'h18F, 0, 16'h12, 16'h0F0F, 0, 1, 2, 0);
    t_hold(1);
    t_hold(0);
    test_done;
  end
endmodule
bind ebc_bus_ctrl ebc_bus_ctrl_properties u_prop (.i_link_clk, .i_rst_n, .i_hold_n,
  .i_onchip_extension_ram_wr_n, .o_cs_n, .o_cs_oe, .o_ctl_oe, .o_rd_n, .o_wr_n, .o_ale,
  .o_bus_release_ack_n, .o_bus_regain_request_n, .o_onchip_extension_ram_we);
